/* common/charger_pkg.sv */
// Constants shared by the charger register bank and its serial target port
package charger_pkg;
   localparam logic [7:0] REG_WDOG        = 8'h00;
   localparam logic [7:0] REG_CTRL        = 8'h01;
   localparam logic [7:0] REG_VBAT        = 8'h02;
   localparam int         WATCHDOG_FAULT_FLAG_BIT    = 7;
   localparam int         WATCHDOG_ENABLE_BIT       = 6;
   localparam int         STATE_LSB       = 4;
   localparam int         SW_RESET_BIT    = 7;
   localparam int         INPUT_LIMIT_RESISTOR_LSB        = 4;
   localparam int         STAT_EN_BIT     = 3;
   localparam int         TERM_EN_BIT     = 2;
   localparam int         CHG_DIS_BIT     = 1;
   localparam int         HIZ_BIT         = 0;
   localparam int         VBAT_LSB        = 2;
   localparam logic       WATCHDOG_ENABLE_RST       = 1'h0;
   localparam logic [7:0] CTRL_RST        = 8'hAC;
   localparam logic [7:0] VBAT_RST        = 8'h8F;
   localparam logic [1:0] CHG_READY       = 2'h0;
   localparam logic [1:0] CHG_BUSY        = 2'h1;
   localparam logic [1:0] CHG_DONE        = 2'h2;
   localparam logic [1:0] CHG_FAULT       = 2'h3;
   localparam logic [3:0] FLT_NORMAL      = 4'h0;
   localparam int         FLT_COUNT       = 10;
   localparam logic [2:0] LIM_100MA       = 3'h0;
   localparam logic [2:0] LIM_500MA       = 3'h2;
   localparam logic [2:0] LIM_EXT         = 3'h6;
   localparam logic [2:0] LIM_NONE        = 3'h7;
   localparam int         VREG_BASE_MV    = 3500;
   localparam int         VREG_STEP_MV    = 20;
   localparam int         VREG_MAX_MV     = 4440;
   localparam int         CLK_PERIOD_NS   = 8;
   localparam int         WD_TIMEOUT_S    = 50;
   localparam int         WD_TICK_MS      = 1;
   localparam int         TICK_CYCLES_DEF = WD_TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         WD_TICKS_DEF    = WD_TIMEOUT_S * 1000 / WD_TICK_MS;
   // Arbitrary bus address
   localparam logic [6:0] DEV_ADDR_DEF    = 7'h35;
   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WR, I2C_WACK, I2C_RD, I2C_RACK
   } i2c_st_e;
endpackage

/* hdl/i2c_target.sv */
// Serial two-wire target: pointer, byte writes and reads with auto-increment
`timescale 1ns/1ps
module i2c_target
   import charger_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
)
(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       scl_pin,
   input  wire logic       sda_pin_in,
   output wire logic       sda_pin_out,
   output wire logic       sda_pin_oe_n,
   output wire logic [7:0] reg_ptr,
   output wire logic [7:0] acc_addr,
   output wire logic       wr_stb,
   output wire logic [7:0] wr_data,
   output wire logic       rd_stb,
   input  wire logic [7:0] rd_data
);
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic       scl_p;
      logic       sda_p;
      i2c_st_e    st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic       rw;
      logic       first;
      logic       ack;
      logic       drv;
      logic [7:0] ptr;
      logic [7:0] addr;
      logic [7:0] wdat;
      logic       wr;
      logic       rd;
   } tgt_s;

   tgt_s q;
   tgt_s n;
   logic scl;
   logic sda;

   assign scl = q.scl_s[1];
   assign sda = q.sda_s[1];

   always_comb
   begin
      n = q;
      n.wr = 1'h0;
      n.rd = 1'h0;
      n.scl_s = {q.scl_s[0], scl_pin};
      n.sda_s = {q.sda_s[0], sda_pin_in};
      n.scl_p = scl;
      n.sda_p = sda;
      if (scl && q.scl_p && q.sda_p && !sda)
      begin
         n.st = I2C_ADDR;
         n.cnt = 4'h0;
         n.drv = 1'h0;
      end
      else if (scl && q.scl_p && !q.sda_p && sda)
      begin
         n.st = I2C_IDLE;
         n.drv = 1'h0;
      end
      else if (scl && !q.scl_p)
      begin
         if (q.st == I2C_ADDR || q.st == I2C_WR)
         begin
            n.sh = {q.sh[6:0], sda};
            n.cnt = q.cnt + 4'h1;
         end
         if (q.st == I2C_RACK)
            n.ack = !sda;
      end
      else if (!scl && q.scl_p)
      begin
         unique case (q.st)
            I2C_IDLE: ;
            I2C_ADDR:
               if (q.cnt == 4'h8)
               begin
                  n.st = (q.sh[7:1] == DEV_ADDR) ? I2C_AACK : I2C_IDLE;
                  n.drv = (q.sh[7:1] == DEV_ADDR);
                  n.rw = q.sh[0];
               end
            I2C_AACK, I2C_RACK:
               if (q.st == I2C_AACK ? q.rw : q.ack)
               begin
                  // Data is fetched at the pointer before it moves on
                  n.st = I2C_RD;
                  n.sh = rd_data;
                  n.rd = 1'h1;
                  n.addr = q.ptr;
                  n.ptr = q.ptr + 8'h01;
                  n.cnt = 4'h1;
                  n.drv = !rd_data[7];
               end
               else
               begin
                  n.st = (q.st == I2C_AACK) ? I2C_WR : I2C_IDLE;
                  n.drv = 1'h0;
                  n.cnt = 4'h0;
                  n.first = 1'h1;
               end
            I2C_WR:
               if (q.cnt == 4'h8)
               begin
                  n.st = I2C_WACK;
                  n.drv = 1'h1;
                  if (q.first)
                     n.ptr = q.sh;
                  else
                  begin
                     n.wr = 1'h1;
                     n.addr = q.ptr;
                     n.wdat = q.sh;
                  end
               end
            I2C_WACK:
            begin
               n.st = I2C_WR;
               n.drv = 1'h0;
               n.cnt = 4'h0;
               n.first = 1'h0;
               if (!q.first)
                  n.ptr = q.ptr + 8'h01;
            end
            I2C_RD:
               if (q.cnt == 4'h8)
               begin
                  n.st = I2C_RACK;
                  n.drv = 1'h0;
               end
               else
               begin
                  n.sh = {q.sh[6:0], 1'h0};
                  n.cnt = q.cnt + 4'h1;
                  n.drv = !q.sh[6];
               end
            default:
               n.st = I2C_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         q <= '0;
      else
         q <= n;
   end

   assign sda_pin_out = 1'h0;
   assign sda_pin_oe_n = !q.drv;
   assign reg_ptr = q.ptr;
   assign acc_addr = q.addr;
   assign wr_stb = q.wr;
   assign wr_data = q.wdat;
   assign rd_stb = q.rd;
endmodule

/* hdl/charger_control_status_regs.sv */
// Charger control and status registers 00h-02h behind a serial target port
`timescale 1ns/1ps
module charger_control_status_regs
   import charger_pkg::*;
#(
   parameter int         TICK_CYCLES     = TICK_CYCLES_DEF,
   parameter int         WD_TICKS        = WD_TICKS_DEF,
   parameter logic [6:0] DEV_ADDR        = DEV_ADDR_DEF,
   parameter bit         USE_PORT_DETECT = 1'h1
)
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        scl_pin,
   input  wire logic        sda_pin_in,
   output wire logic        sda_pin_out,
   output wire logic        sda_pin_oe_n,
   input  wire logic [1:0]  charge_state_in,
   input  wire logic        stat_request,
   input  wire logic [8:0]  fault_cond,
   input  wire logic        ldo_low,
   input  wire logic        uvlo_exit,
   input  wire logic        battery_present,
   input  wire logic [1:0]  port_detect_result,
   input  wire logic        strap_pin_1,
   input  wire logic        strap_pin_0,
   output wire logic        stat_pin_out,
   output wire logic        stat_pin_oe_n,
   output wire logic        termination_enable,
   output wire logic        charge_enable,
   output wire logic        battery_switch_on,
   output wire logic        converter_enable,
   output wire logic [2:0]  input_limit_eff,
   output wire logic        production_test_mode,
   output wire logic [5:0]  battery_regulation_voltage,
   output wire logic [12:0] vbat_reg_mv,
   output wire logic        host_mode
);
   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam int TW = $clog2(WD_TICKS + 1);

   typedef struct packed {
      logic                 watchdog_enable;
      logic                 watchdog_fault_flag;
      logic                 host;
      logic [6:0]           ctrl;
      logic [5:0]           vbat;
      logic [PW-1:0]        pre;
      logic [TW-1:0]        ticks;
      logic [FLT_COUNT-1:0] pend;
      logic [FLT_COUNT-1:0] prev;
      logic [1:0]           strap_s1;
      logic [1:0]           strap_s2;
   } regs_s;

   localparam regs_s RST_VAL = '{
      watchdog_enable:    WATCHDOG_ENABLE_RST,
      ctrl:     CTRL_RST[6:0],
      vbat:     VBAT_RST[7:VBAT_LSB],
      default:  '0
   };

   regs_s                q;
   regs_s                n;
   logic [7:0]           reg_ptr;
   logic [7:0]           acc_addr;
   logic                 wr_stb;
   logic [7:0]           wr_data;
   logic                 rd_stb;
   logic [7:0]           rd_data;
   logic [FLT_COUNT-1:0] live;
   logic [FLT_COUNT-1:0] pop_mask;
   logic [3:0]           head_code;
   logic [3:0]           fault_rd;
   logic [1:0]           state_rd;
   logic [1:0]           det;
   logic                 tick;
   logic                 expire;
   logic [2:0]           input_limit_resistor;
   logic                 stat_en;
   logic                 term_en;
   logic                 chg_dis;
   logic                 hiz;
   int                   mv;

   // Lowest numbered code wins, so a burst drains in a fixed order
   function automatic logic [3:0] first_code(input logic [FLT_COUNT-1:0] v);
      first_code = FLT_NORMAL;
      for (int i = FLT_COUNT - 1; i >= 0; i--)
      begin
         if (v[i])
            first_code = 4'(i + 1);
      end
   endfunction

   // Restores the charge parameters held in 01h and 02h
   function automatic regs_s load_defaults(input regs_s s);
      load_defaults = s;
      load_defaults.ctrl = RST_VAL.ctrl;
      load_defaults.vbat = RST_VAL.vbat;
   endfunction

   i2c_target #(
      .DEV_ADDR (DEV_ADDR)
   ) u_target (
      .ref_clk      (ref_clk),
      .nrst         (nrst),
      .scl_pin      (scl_pin),
      .sda_pin_in   (sda_pin_in),
      .sda_pin_out  (sda_pin_out),
      .sda_pin_oe_n (sda_pin_oe_n),
      .reg_ptr      (reg_ptr),
      .acc_addr     (acc_addr),
      .wr_stb       (wr_stb),
      .wr_data      (wr_data),
      .rd_stb       (rd_stb),
      .rd_data      (rd_data)
   );

   assign input_limit_resistor = q.ctrl[INPUT_LIMIT_RESISTOR_LSB+2:INPUT_LIMIT_RESISTOR_LSB];
   assign stat_en = q.ctrl[STAT_EN_BIT];
   assign term_en = q.ctrl[TERM_EN_BIT];
   assign chg_dis = q.ctrl[CHG_DIS_BIT];
   assign hiz = q.ctrl[HIZ_BIT];

   // Code 10 needs the undervoltage code 2 input or its recovery phase
   assign live = {ldo_low & (fault_cond[1] | uvlo_exit), fault_cond};

   assign head_code = first_code(q.pend);
   assign fault_rd = (q.pend != '0) ? head_code : first_code(live);
   assign pop_mask = (q.pend != '0) ? FLT_COUNT'(1) << (head_code - 4'h1) : '0;

   // A hidden done state keeps software from seeing a termination
   assign state_rd = (!term_en && charge_state_in == CHG_DONE) ? CHG_BUSY
                                                               : charge_state_in;

   assign det = USE_PORT_DETECT ? port_detect_result : q.strap_s2;

   assign tick = (q.pre == PW'(TICK_CYCLES - 1));
   assign expire = q.watchdog_enable && q.host && tick && q.ticks == TW'(WD_TICKS - 1) && !wr_stb;

   always_comb
   begin
      unique case (reg_ptr)
         REG_WDOG: rd_data = {q.watchdog_fault_flag, q.watchdog_enable, state_rd, fault_rd};
         REG_CTRL: rd_data = {1'h0, q.ctrl};
         REG_VBAT: rd_data = {q.vbat, det};
         default:  rd_data = 8'h00;
      endcase
   end

   always_comb
   begin
      n = q;
      n.strap_s1 = {strap_pin_1, strap_pin_0};
      n.strap_s2 = q.strap_s1;
      n.prev = live;
      if (rd_stb && acc_addr == REG_WDOG)
      begin
         n.pend = q.pend & ~pop_mask;
         n.watchdog_fault_flag = 1'h0;
      end
      // New faults are set after the pop so a same-cycle event survives
      n.pend = n.pend | (live & ~q.prev);
      // Timer runs only in host mode with the enable set
      if (!q.watchdog_enable || !q.host || wr_stb || expire)
      begin
         n.pre = '0;
         n.ticks = '0;
      end
      else if (tick)
      begin
         n.pre = '0;
         n.ticks = q.ticks + TW'(1);
      end
      else
         n.pre = q.pre + PW'(1);
      if (expire)
      begin
         n = load_defaults(n);
         n.host = 1'h0;
         n.watchdog_fault_flag = 1'h1;
      end
      if (wr_stb)
      begin
         n.host = 1'h1;
         unique case (acc_addr)
            REG_WDOG: n.watchdog_enable = wr_data[WATCHDOG_ENABLE_BIT];
            REG_CTRL:
               if (wr_data[SW_RESET_BIT])
               begin
                  n = load_defaults(n);
                  n.watchdog_enable = RST_VAL.watchdog_enable;
                  n.watchdog_fault_flag = 1'h0;
               end
               else
                  n.ctrl = wr_data[6:0];
            REG_VBAT: n.vbat = wr_data[7:VBAT_LSB];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         q <= RST_VAL;
      else
         q <= n;
   end

   // Standalone mode, or a refused test mode, falls back to the resistor
   assign input_limit_eff = !q.host ? LIM_EXT :
                            (input_limit_resistor == LIM_NONE && battery_present) ? LIM_EXT : input_limit_resistor;
   assign production_test_mode = q.host && input_limit_resistor == LIM_NONE && !battery_present;

   assign stat_pin_out = 1'h0;
   assign stat_pin_oe_n = !(stat_en && stat_request
                            && !(!term_en && charge_state_in == CHG_DONE));
   assign termination_enable = term_en;
   assign charge_enable = !chg_dis;
   // Standby must keep the system fed from the cell, so it overrides disable
   assign battery_switch_on = hiz || !chg_dis;
   assign converter_enable = !hiz;
   assign host_mode = q.host;

   assign battery_regulation_voltage = q.vbat;
   assign mv = VREG_BASE_MV + VREG_STEP_MV * int'(q.vbat);
   assign vbat_reg_mv = (mv > VREG_MAX_MV) ? 13'(VREG_MAX_MV) : 13'(mv);

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   wd_enable_wr_a: assert property (
      wr_stb && acc_addr == REG_WDOG |=> q.watchdog_enable == $past(wr_data[WATCHDOG_ENABLE_BIT]))
      else $error("watchdog enable not taken from write");

   wd_expire_a: assert property (
      expire |=> q.watchdog_fault_flag && !q.host && q.ctrl == CTRL_RST[6:0] && q.ticks == '0)
      else $error("watchdog expiry did not flag and reload");

   sw_reset_a: assert property (
      wr_stb && acc_addr == REG_CTRL && wr_data[SW_RESET_BIT]
      |=> q.ctrl == CTRL_RST[6:0] && q.vbat == VBAT_RST[7:VBAT_LSB] && !q.watchdog_enable)
      else $error("software reset did not restore defaults");

   reset_bit_rd_a: assert property (
      reg_ptr == REG_CTRL |-> rd_data[SW_RESET_BIT] == 1'h0 && rd_data[6:0] == q.ctrl)
      else $error("reset bit did not read as zero");

   ptm_refuse_a: assert property (
      battery_present |-> !production_test_mode && input_limit_eff != LIM_NONE)
      else $error("test mode entered with battery present");

   standalone_lim_a: assert property (
      !q.host |-> input_limit_eff == LIM_EXT)
      else $error("standalone mode not using limit resistor");

   stat_release_a: assert property (
      !stat_en |-> stat_pin_oe_n)
      else $error("status pin driven while disabled");

   term_hide_a: assert property (
      !term_en && reg_ptr == REG_WDOG |-> rd_data[STATE_LSB+1:STATE_LSB] != CHG_DONE)
      else $error("termination shown while disabled");

   chg_off_a: assert property (
      chg_dis && !hiz |-> !battery_switch_on && converter_enable)
      else $error("battery switch closed while charge disabled");

   hiz_mode_a: assert property (
      hiz |-> !converter_enable && battery_switch_on)
      else $error("standby did not stop converter");

   fault_normal_a: assert property (
      fault_rd == FLT_NORMAL |-> q.pend == '0 && live == '0)
      else $error("normal fault code with faults pending");

   fault_pop_a: assert property (
      rd_stb && acc_addr == REG_WDOG && q.pend != '0 && (live & ~q.prev) == '0
      |=> $countones(q.pend) == $countones($past(q.pend)) - 1)
      else $error("fault read did not advance queue");

   watchdog_fault_flag_set_a: assert property (
      $rose(q.watchdog_fault_flag) |-> $past(expire))
      else $error("watchdog fault set without expiry");
endmodule

/* verification/i2c_host_model.sv */
// Host processor model: two-wire bus controller with register access tasks
`timescale 1ns/1ps
module i2c_host_model
#(
   parameter logic [6:0] DEV_ADDR = 7'h35
)
(
   output logic      scl_pin,
   output logic      sda_host,
   input  wire logic sda_wire
);
   localparam real H = 62.5;
   int nak_count = 0;
   initial
   begin
      scl_pin = 1'b1;
      sda_host = 1'b1;
   end
   // Also a repeated start; data rises while the clock is low, then falls while it is high
   task automatic start_c;
      #(H/2) sda_host = 1'b1;
      #(H/2) scl_pin = 1'b1;
      #H sda_host = 1'b0;
      #H scl_pin = 1'b0;
   endtask
   task automatic stop_c;
      #(H/2) sda_host = 1'b0;
      #(H/2) scl_pin = 1'b1;
      #H sda_host = 1'b1;
      #H;
   endtask
   task automatic bit_x(input logic b, output logic r);
      #(H/2) sda_host = b;
      #(H/2) scl_pin = 1'b1;
      #H r = sda_wire;
      scl_pin = 1'b0;
   endtask
   // Bit 9 is our acknowledge on reads, the target's on writes
   task automatic byte_x(input logic [7:0] b, input logic a, input logic chk,
                         output logic [7:0] r);
      logic ack;
      for (int i = 7; i >= 0; i--)
         bit_x(b[i], r[i]);
      bit_x(a, ack);
      if (chk && ack !== 1'b0)
         nak_count++;
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      start_c();
      byte_x({DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
      byte_x(a, 1'b1, 1'b1, r);
      byte_x(d, 1'b1, 1'b1, r);
      stop_c();
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      start_c();
      byte_x({DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
      byte_x(a, 1'b1, 1'b1, r);
      start_c();
      byte_x({DEV_ADDR, 1'b1}, 1'b1, 1'b1, r);
      byte_x(8'hFF, 1'b1, 1'b0, d);
      stop_c();
   endtask
endmodule

/* verification/charger_control_status_regs_tb.sv */
// Self-checking bench for the charger register bank over its serial port
`timescale 1ns/1ps
module charger_control_status_regs_tb
   import charger_pkg::*;
;
   logic        ref_clk;
   logic        nrst;
   logic        scl_pin;
   logic        sda_host;
   wire         sda_wire;
   logic [1:0]  charge_state_in;
   logic        stat_request;
   logic [8:0]  fault_cond;
   logic        ldo_low;
   logic        uvlo_exit;
   logic        battery_present;
   logic [1:0]  port_detect_result;
   logic        sda_pin_out;
   logic        sda_pin_oe_n;
   logic        stat_pin_out;
   logic        stat_pin_oe_n;
   logic        termination_enable;
   logic        charge_enable;
   logic        battery_switch_on;
   logic        converter_enable;
   logic [2:0]  input_limit_eff;
   logic        production_test_mode;
   logic [5:0]  battery_regulation_voltage;
   logic [12:0] vbat_reg_mv;
   logic        host_mode;
   logic [7:0]  rd;
   int          n_errors = 0;
   int          num_checks = 0;
   // Pull-up on the data wire
   assign sda_wire = sda_host & (sda_pin_oe_n | sda_pin_out);
   i2c_host_model host_u (.scl_pin, .sda_host, .sda_wire);
   charger_control_status_regs #(.TICK_CYCLES(4), .WD_TICKS(10)) dut_u (
      .ref_clk, .nrst, .scl_pin, .sda_pin_in(sda_wire), .sda_pin_out, .sda_pin_oe_n,
      .charge_state_in, .stat_request, .fault_cond, .ldo_low, .uvlo_exit,
      .battery_present, .port_detect_result, .strap_pin_1(1'b0), .strap_pin_0(1'b0),
      .stat_pin_out, .stat_pin_oe_n, .termination_enable, .charge_enable,
      .battery_switch_on, .converter_enable, .input_limit_eff, .production_test_mode,
      .battery_regulation_voltage, .vbat_reg_mv, .host_mode);
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      n_errors += host_u.nak_count;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Serial traffic takes near 170 us; the limit is 400 us
   initial
   begin
      #400000;
      n_errors++;
      finish_test();
   end
   initial
   begin
      nrst = 1'b0;
      charge_state_in = 2'h1;
      stat_request = 1'b0;
      fault_cond = 9'h000;
      ldo_low = 1'b0;
      uvlo_exit = 1'b0;
      battery_present = 1'b1;
      port_detect_result = 2'h2;
      cyc(8);
      nrst = 1'b1;
      cyc(4);
      host_u.read_reg(REG_CTRL, rd);
      check(rd, 8'h2C);
      host_u.read_reg(REG_VBAT, rd);
      check(rd, 8'h8E);
      check({host_mode, input_limit_eff}, 4'h6);
      check({termination_enable, charge_enable, battery_switch_on, converter_enable}, 4'hF);
      check(vbat_reg_mv, 16'(VREG_BASE_MV + 6'h23 * VREG_STEP_MV));
      check(battery_regulation_voltage, 6'h23);
      check({sda_pin_out, stat_pin_out}, 2'h0);
      cyc(1);
      stat_request = 1'b1;
      cyc(2);
      check(stat_pin_oe_n, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         cyc(1);
         charge_state_in = i[1:0];
         host_u.read_reg(REG_WDOG, rd);
         check(rd, {2'h0, i[1:0], 4'h0});
      end
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         host_u.write_reg(REG_CTRL, {1'b0, i[2:0], 4'hC});
         check({host_mode, input_limit_eff}, {1'b1, i[2:0]});
      end
      host_u.write_reg(REG_CTRL, {1'b0, LIM_NONE, 4'hC});
      check({production_test_mode, input_limit_eff}, {1'b0, LIM_EXT});
      cyc(1);
      battery_present = 1'b0;
      cyc(2);
      check({production_test_mode, input_limit_eff}, {1'b1, LIM_NONE});
      battery_present = 1'b1;
      $display("test limit done");
      charge_state_in = 2'h2;
      host_u.write_reg(REG_CTRL, 8'h2A);
      check({termination_enable, charge_enable, battery_switch_on, converter_enable}, 4'h1);
      check(stat_pin_oe_n, 1'b1);
      host_u.read_reg(REG_WDOG, rd);
      check(rd, 8'h10);
      cyc(1);
      charge_state_in = 2'h1;
      host_u.write_reg(REG_CTRL, 8'h23);
      check({termination_enable, charge_enable, battery_switch_on, converter_enable}, 4'h2);
      check(stat_pin_oe_n, 1'b1);
      host_u.read_reg(REG_CTRL, rd);
      check(rd, 8'h23);
      host_u.write_reg(REG_CTRL, 8'h80);
      host_u.read_reg(REG_CTRL, rd);
      check(rd, 8'h2C);
      $display("test control done");
      host_u.write_reg(REG_VBAT, 8'hFF);
      host_u.read_reg(REG_VBAT, rd);
      check(rd, 8'hFE);
      check(vbat_reg_mv, 16'(VREG_MAX_MV));
      check(battery_regulation_voltage, 6'h3F);
      host_u.write_reg(REG_VBAT, 8'h00);
      cyc(1);
      port_detect_result = 2'h1;
      host_u.read_reg(REG_VBAT, rd);
      check(rd, 8'h01);
      check(vbat_reg_mv, VREG_BASE_MV);
      host_u.write_reg(8'h03, 8'h55);
      host_u.read_reg(8'h03, rd);
      check(rd, 8'h00);
      $display("test voltage done");
      cyc(1);
      fault_cond = 9'h012;
      cyc(2);
      fault_cond = 9'h000;
      cyc(2);
      host_u.read_reg(REG_WDOG, rd);
      check(rd, 8'h12);
      host_u.read_reg(REG_WDOG, rd);
      check(rd, 8'h15);
      host_u.read_reg(REG_WDOG, rd);
      check(rd, 8'h10);
      cyc(1);
      ldo_low = 1'b1;
      uvlo_exit = 1'b1;
      host_u.read_reg(REG_WDOG, rd);
      check(rd, 8'h1A);
      host_u.read_reg(REG_WDOG, rd);
      check(rd, 8'h1A);
      cyc(1);
      ldo_low = 1'b0;
      uvlo_exit = 1'b0;
      host_u.read_reg(REG_WDOG, rd);
      check(rd, 8'h10);
      $display("test fault done");
      host_u.write_reg(REG_CTRL, 8'h1A);
      host_u.write_reg(REG_WDOG, 8'h40);
      cyc(100);
      check({host_mode, input_limit_eff}, 4'h6);
      check(battery_regulation_voltage, 6'h23);
      // Disable first so the flag cannot be set again mid-read
      host_u.write_reg(REG_WDOG, 8'h00);
      host_u.read_reg(REG_CTRL, rd);
      check(rd, 8'h2C);
      host_u.read_reg(REG_WDOG, rd);
      check(rd & 8'hC0, 8'h80);
      host_u.read_reg(REG_WDOG, rd);
      check(rd & 8'h80, 8'h00);
      cyc(100);
      check(host_mode, 1'b1);
      $display("test watchdog done");
      finish_test();
   end
endmodule
